// >>> rtl/card_map.svh
// register offsets, field positions, masks and reset values for the adapter datapath
`ifndef CARD_MAP_SVH
`define CARD_MAP_SVH
`define CARD_DS_ADDR      4'h0
`define CARD_CS_ADDR      4'h1
`define CARD_BA_ADDR      4'h2
`define CARD_BC_ADDR      4'h3
`define CARD_OS_ADDR      4'h4
`define CARD_OR_ADDR      4'h5
`define CARD_ST_ADDR      4'h6
`define CARD_ZERO16       16'h0000
`define CARD_ZERO8        8'h00
`define CARD_ONES16       16'hffff
`define CARD_BIT_NXM      4'he
`define CARD_BIT_SELECTIVE_RESET_FLAG   4'hd
`define CARD_BIT_SYSTEM_RESET_FLAG   4'hc
`define CARD_BIT_DISC     4'hb
`define CARD_BIT_DEND     4'h7
`define CARD_BIT_PARITY_ERROR_FLAG    4'h5
`define CARD_BIT_SELREJ   4'h3
`define CARD_CS_FN_LO     4'h1
`define CARD_CS_GO        4'h0
`define CARD_CS_BUSY      4'h3
`define CARD_CS_DX        4'h4
`define CARD_CS_LOCK      4'hf
`define CARD_CS_MASK      16'h800e
`define CARD_DS_KEEP      16'h3808
`define CARD_OR_MASK      16'hfcff
`define CARD_INC1         16'h0001
`define CARD_INC2         16'h0002
`define CARD_FN_STATUS    2'h3
`endif

// >>> rtl/card_pkg.sv
// types for the adapter register datapath
package card_pkg;
  typedef enum logic [1:0] {
    CARD_BUS_IDLE = 2'h0,
    CARD_BUS_ACK  = 2'h1
  } card_bus_t;
endpackage

// >>> rtl/card_regs.sv
// register datapath of the channel adapter with a classic wishbone slave
// Behaviour
// - status flags set-only except bit 3, cleared by device reset or init except bits 13, 12, 11 and 3
// - bit 14 flags nonexistent memory on timeout
// - parity flag sets in phase 3 ts1
// - system reset direct-set; rejected flag clocked to zero
// - busy cleared only by host control write; function clears on device reset or init in phase 7
// - control clear from device reset or init
// - control bits load from host data when unlocked
// - maintenance clock: only function and go load
// - address counter loads the value plus one on the same edge
// - address adds two in phase 5 ts1
// - host write loads address bits 15 to 1
// - phase 1 loads shifted unit address ORed with offset
// - phase 2 loads pointer and command byte
// - phase 4 loads shifted table index
// - byte counter counts up from negative count
// - last byte sets device end and done
// - host low-byte write loads unit status byte
// - phase 1 ts2 status takes transfer low byte
// - phase 2 ts2 picks byte by command bit
// - phase 5 and 6 ts2 status byte sources
// - status nonzero during sequence or status function
// - offset writable off-line only, bits 9,8 unused
// - table index shifted left one into address
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`include "card_map.svh"
module card_regs
  import card_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        device_reset,
  input  wire logic        bus_init,
  input  wire logic [2:0]  phase,
  input  wire logic        time_state_one,
  input  wire logic        time_state_two,
  input  wire logic        sync_flag,
  input  wire logic        transfer_request_pending,
  input  wire logic        transfer_granted,
  input  wire logic        bypass_flag,
  input  wire logic        parity_bad,
  input  wire logic        host_bus_timeout,
  input  wire logic        reset_system,
  input  wire logic        reset_selective,
  input  wire logic        reset_disconnect,
  input  wire logic        reject_set,
  input  wire logic        reject_clock,
  input  wire logic        phase7_clear_signal,
  input  wire logic        maint_clock_mode,
  input  wire logic        offline,
  input  wire logic        channel_initiated_sequence,
  input  wire logic        data_step_in,
  input  wire logic        data_step_out,
  input  wire logic [7:0]  unit_address_byte,
  input  wire logic [7:0]  bus_out,
  input  wire logic [15:0] transfer_data_register,
  input  wire logic [7:0]  table_entry_index,
  input  wire logic        unit_busy_set,
  output logic      [15:0] bus_address_counter,
  output logic      [7:0]  unit_status_byte,
  output logic             io_done_signal,
  output logic             status_nonzero,
  output logic      [1:0]  function_bits,
  output logic             go_bit
);
  card_bus_t   bus_reg;
  logic [15:0] device_status_register;
  logic [15:0] control_status_register;
  logic [15:0] byte_counter;
  logic [15:0] unit_offset_register;
  logic [7:0]  command_byte;
  logic [15:0] ba_next;
  logic [15:0] ds_set;
  logic [7:0]  us_next;
  logic [15:0] rd_mux;
  wire req       = wb_cyc_i & wb_stb_i & (bus_reg == CARD_BUS_IDLE);
  wire wr_lo     = req & wb_we_i & wb_sel_i[0];
  wire wr_hi     = req & wb_we_i & wb_sel_i[1];
  wire [3:0] ra  = wb_adr_i[5:2];
  wire locked    = control_status_register[`CARD_CS_LOCK];
  wire cs_wr     = wr_lo & wr_hi & (ra == `CARD_CS_ADDR) & ~locked;
  wire ba_wr     = wr_lo & wr_hi & (ra == `CARD_BA_ADDR) & ~locked;
  wire bc_wr     = wr_lo & wr_hi & (ra == `CARD_BC_ADDR);
  wire us_wr     = wr_lo & (ra == `CARD_OS_ADDR) & ~locked;
  wire or_wr     = wr_lo & wr_hi & (ra == `CARD_OR_ADDR) & offline;
  wire clr_all   = device_reset | bus_init;
  wire cs_clear  = clr_all;
  wire fn_clear  = cs_clear & phase7_clear_signal & time_state_one;
  wire ts1_p1    = time_state_one & (phase == 3'h1);
  wire ts1_p2    = time_state_one & (phase == 3'h2);
  wire ts1_p4    = time_state_one & (phase == 3'h4);
  wire ts1_p5    = time_state_one & (phase == 3'h5);
  wire ts2_p1    = time_state_two & (phase == 3'h1) & transfer_granted;
  wire ts2_p2    = time_state_two & (phase == 3'h2);
  wire ts2_p5    = time_state_two & (phase == 3'h5);
  wire ts2_p6    = time_state_two & (phase == 3'h6) & data_step_out;
  wire data_step = data_step_in | data_step_out;
  wire last_byte = data_step & (byte_counter == `CARD_ONES16);
  wire par_set   = time_state_one & (phase == 3'h3) & ~bypass_flag & parity_bad;
  wire ba_load   = ba_wr | ts1_p1 | ts1_p2 | ts1_p4;
  wire ba_plus2  = ts1_p5 & sync_flag & ~transfer_request_pending;
  wire [15:0] ua_shift = {7'h00, unit_address_byte, 1'b0};
  wire [15:0] tx_shift = {7'h00, table_entry_index, 1'b0};
  wire gated_ok  = ~maint_clock_mode;
  always_comb begin
    ba_next = bus_address_counter;
    if (ba_wr) begin
      ba_next = {wb_dat_i[15:1], 1'b0};
    end else if (ts1_p1) begin
      ba_next = ua_shift | unit_offset_register;
    end else if (ts1_p2) begin
      ba_next = {transfer_data_register[15:8], bus_out};
    end else if (ts1_p4) begin
      ba_next = tx_shift;
    end
  end
  always_comb begin
    ds_set = `CARD_ZERO16;
    ds_set[`CARD_BIT_NXM]    = host_bus_timeout;
    ds_set[`CARD_BIT_PARITY_ERROR_FLAG]  = par_set;
    ds_set[`CARD_BIT_DEND]   = last_byte;
    ds_set[`CARD_BIT_DISC]   = reset_disconnect;
    ds_set[`CARD_BIT_SYSTEM_RESET_FLAG] = reset_system;
    ds_set[`CARD_BIT_SELECTIVE_RESET_FLAG] = reset_selective;
  end
  always_comb begin
    us_next = unit_status_byte;
    if (us_wr) begin
      us_next = wb_dat_i[7:0];
    end else if (ts2_p1) begin
      us_next = transfer_data_register[7:0];
    end else if (ts2_p2) begin
      us_next = command_byte[0] ? transfer_data_register[15:8]
                                : transfer_data_register[7:0];
    end else if (ts2_p5) begin
      us_next = bus_out;
    end else if (ts2_p6) begin
      us_next = transfer_data_register[7:0];
    end
  end
  assign rd_mux = (ra == `CARD_DS_ADDR) ? device_status_register :
                  (ra == `CARD_CS_ADDR) ? control_status_register :
                  (ra == `CARD_BA_ADDR) ? bus_address_counter :
                  (ra == `CARD_BC_ADDR) ? byte_counter :
                  (ra == `CARD_OS_ADDR) ? {command_byte, unit_status_byte} :
                  (ra == `CARD_OR_ADDR) ? unit_offset_register : `CARD_ZERO16;
  assign status_nonzero = (|unit_status_byte) &
    (channel_initiated_sequence | (function_bits == `CARD_FN_STATUS));
  assign io_done_signal = device_status_register[`CARD_BIT_DEND];
  assign function_bits  = control_status_register[2:1];
  assign go_bit         = control_status_register[`CARD_CS_GO];
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bus_reg  <= CARD_BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      bus_reg  <= req ? CARD_BUS_ACK : CARD_BUS_IDLE;
      wb_ack_o <= req;
      wb_dat_o <= req ? {16'h0000, rd_mux} : wb_dat_o;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      device_status_register <= `CARD_ZERO16;
    end else begin
      device_status_register <= (clr_all ? (device_status_register & `CARD_DS_KEEP)
                                : device_status_register) | ds_set;
      if (reject_set) begin
        device_status_register[`CARD_BIT_SELREJ] <= 1'b1;
      end else if (reject_clock) begin
        device_status_register[`CARD_BIT_SELREJ] <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      control_status_register <= `CARD_ZERO16;
    end else begin
      if (cs_clear) begin
        control_status_register <= control_status_register & `CARD_CS_MASK;
        control_status_register[`CARD_CS_LOCK] <= 1'b0;
      end else if (cs_wr) begin
        control_status_register[2:0] <= wb_dat_i[2:0];
        if (gated_ok) begin
          control_status_register[15:3] <= wb_dat_i[15:3];
        end
      end
      if (fn_clear) begin
        control_status_register[2:1] <= 2'h0;
      end
      if (unit_busy_set) begin
        control_status_register[`CARD_CS_BUSY] <= 1'b1;
      end
      if (last_byte) begin
        control_status_register[`CARD_CS_DX] <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bus_address_counter <= `CARD_ZERO16;
    end else if (device_reset) begin
      bus_address_counter <= `CARD_ZERO16;
    end else if (ba_load) begin
      bus_address_counter <= ba_next + `CARD_INC1;
    end else if (ba_plus2) begin
      bus_address_counter <= bus_address_counter + `CARD_INC2;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      byte_counter <= `CARD_ZERO16;
    end else if (device_reset) begin
      byte_counter <= `CARD_ZERO16;
    end else if (bc_wr) begin
      byte_counter <= wb_dat_i[15:0];
    end else if (data_step) begin
      byte_counter <= byte_counter + `CARD_INC1;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      unit_status_byte <= `CARD_ZERO8;
      command_byte     <= `CARD_ZERO8;
    end else if (device_reset) begin
      unit_status_byte <= `CARD_ZERO8;
      command_byte     <= `CARD_ZERO8;
    end else begin
      unit_status_byte <= us_next;
      command_byte     <= ts1_p2 ? bus_out : command_byte;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      unit_offset_register <= `CARD_ZERO16;
    end else if (clr_all) begin
      unit_offset_register <= `CARD_ZERO16;
    end else if (or_wr) begin
      unit_offset_register <= wb_dat_i[15:0] & `CARD_OR_MASK;
    end
  end
  wb_ack_one_a: assert property (@(posedge clock) disable iff (!arst_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  ba_plus_two_a: assert property (@(posedge clock) disable iff (!arst_n)
    ba_plus2 && !ba_load && !device_reset |=>
    bus_address_counter == $past(bus_address_counter) + 16'h0002)
    else $error("address did not add two");
  ba_load_inc_a: assert property (@(posedge clock) disable iff (!arst_n)
    ba_load && !device_reset |=> bus_address_counter == $past(ba_next) + 16'h0001)
    else $error("address load not plus one");
  nxm_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    host_bus_timeout |=> device_status_register[14]) else $error("nxm not set");
  busy_keep_a: assert property (@(posedge clock) disable iff (!arst_n)
    control_status_register[3] && !cs_wr |=> control_status_register[3])
    else $error("busy cleared");
  done_sets_a: assert property (@(posedge clock) disable iff (!arst_n)
    last_byte |=> io_done_signal && !control_status_register[4])
    else $error("done not signalled");
  off_write_a: assert property (@(posedge clock) disable iff (!arst_n)
    1'b1 |-> unit_offset_register[9:8] == 2'h0) else $error("offset bits used");
  us_write_a: assert property (@(posedge clock) disable iff (!arst_n)
    us_wr && !device_reset |=> unit_status_byte == $past(wb_dat_i[7:0]))
    else $error("status byte not loaded");
  // a taken request is answered on the next edge and the answer lasts one cycle
  sequence wb_take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence wb_answer_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  wb_answer_a: assert property (@(posedge clock) disable iff (!arst_n)
    wb_take_s |=> wb_answer_s) else $error("request not answered");
  cs_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
    cs_clear |=> !control_status_register[`CARD_CS_LOCK] && !go_bit)
    else $error("control clear missed");
  fn_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    cs_clear && !fn_clear |=> function_bits == $past(function_bits))
    else $error("function cleared without phase 7");
  fn_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
    fn_clear |=> function_bits == 2'h0) else $error("function not cleared");
  ds_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
    clr_all && !(|ds_set) && !reject_set && !reject_clock |=>
    device_status_register == ($past(device_status_register) & `CARD_DS_KEEP))
    else $error("status clear wrong");
  ds_setonly_a: assert property (@(posedge clock) disable iff (!arst_n)
    !clr_all && !reject_clock |=> (device_status_register & $past(device_status_register))
    == $past(device_status_register)) else $error("status flag fell");
  system_reset_flag_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    reset_system |=> device_status_register[`CARD_BIT_SYSTEM_RESET_FLAG]) else $error("system_reset_flag not set");
  rej_clock_a: assert property (@(posedge clock) disable iff (!arst_n)
    reject_clock && !reject_set |=> !device_status_register[`CARD_BIT_SELREJ]) else $error("rej kept");
  par_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    time_state_one && phase == 3'h3 && !bypass_flag && parity_bad |=>
    device_status_register[`CARD_BIT_PARITY_ERROR_FLAG]) else $error("parity not set");
  par_bypass_a: assert property (@(posedge clock) disable iff (!arst_n)
    !clr_all && bypass_flag |=> device_status_register[`CARD_BIT_PARITY_ERROR_FLAG] ==
    $past(device_status_register[`CARD_BIT_PARITY_ERROR_FLAG])) else $error("parity set in bypass");
  bc_step_a: assert property (@(posedge clock) disable iff (!arst_n)
    data_step && !bc_wr && !device_reset |=> byte_counter == $past(byte_counter) + 16'h0001)
    else $error("count did not step");
  bc_reset_a: assert property (@(posedge clock) disable iff (!arst_n)
    device_reset |=> byte_counter == `CARD_ZERO16) else $error("count not cleared");
  ba_reset_a: assert property (@(posedge clock) disable iff (!arst_n)
    device_reset |=> bus_address_counter == `CARD_ZERO16) else $error("address not cleared");
  lock_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    locked && !cs_clear && !unit_busy_set && !last_byte |=> $stable(control_status_register))
    else $error("locked control changed");
  maint_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    cs_wr && maint_clock_mode && !unit_busy_set && !last_byte |=>
    control_status_register[15:3] == $past(control_status_register[15:3])) else $error("maint load");
  ba_host_a: assert property (@(posedge clock) disable iff (!arst_n)
    ba_wr && !device_reset |=> bus_address_counter == {$past(wb_dat_i[15:1]), 1'b1})
    else $error("host address load wrong");
  us_p1_a: assert property (@(posedge clock) disable iff (!arst_n)
    ts2_p1 && !us_wr && !device_reset |=> unit_status_byte == $past(transfer_data_register[7:0]))
    else $error("phase 1 status load wrong");
  us_p2_a: assert property (@(posedge clock) disable iff (!arst_n)
    ts2_p2 && !us_wr && !device_reset |=> unit_status_byte == ($past(command_byte[0]) ?
    $past(transfer_data_register[15:8]) : $past(transfer_data_register[7:0])))
    else $error("phase 2 status load wrong");
  us_p5_a: assert property (@(posedge clock) disable iff (!arst_n)
    ts2_p5 && !us_wr && !device_reset |=> unit_status_byte == $past(bus_out))
    else $error("phase 5 status load wrong");
  us_p6_a: assert property (@(posedge clock) disable iff (!arst_n)
    ts2_p6 && !us_wr && !device_reset |=> unit_status_byte == $past(transfer_data_register[7:0]))
    else $error("phase 6 status load wrong");
  ba_p1_a: assert property (@(posedge clock) disable iff (!arst_n)
    ts1_p1 && !ba_wr && !device_reset |=>
    bus_address_counter == $past(ua_shift | unit_offset_register) + 16'h0001) else $error("p1 addr");
  ba_index_a: assert property (@(posedge clock) disable iff (!arst_n)
    ts1_p4 && !ba_wr && !device_reset |=>
    bus_address_counter == {7'h00, $past(table_entry_index), 1'b0} + 16'h0001) else $error("p4 addr");
  // the last data step wraps the counter to zero and raises done
  sequence last_step_s;
    data_step && byte_counter == `CARD_ONES16 && !bc_wr && !device_reset;
  endsequence
  sequence count_done_s;
    byte_counter == `CARD_ZERO16 && io_done_signal;
  endsequence
  bc_wrap_a: assert property (@(posedge clock) disable iff (!arst_n)
    last_step_s |=> count_done_s) else $error("count did not end at zero");
endmodule // card_regs

// >>> tb/card_seq_model.sv
// phase sequencer stand-in that presents one phase and time state per request
`timescale 1ns/1ns
module card_seq_model (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       run,
  input  wire logic [2:0] req_phase,
  input  wire logic [1:0] req_ts,
  output logic      [2:0] phase,
  output logic            time_state_one,
  output logic            time_state_two
);
  // phase lines change only on the clock edge, idle at phase 0
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase          <= 3'h0;
      time_state_one <= 1'b0;
      time_state_two <= 1'b0;
    end else begin
      phase          <= run ? req_phase : 3'h0;
      time_state_one <= run & req_ts[0];
      time_state_two <= run & req_ts[1];
    end
  end
endmodule // card_seq_model

// >>> tb/card_regs_tb.sv
// self-checking bench for the adapter register datapath
`timescale 1ns/1ns
module card_regs_tb;
  logic        clock = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, wb_dat_o, rnd = 32'h98c5;
  logic        wb_ack_o, io_done, snz, go_bit, maint = 0, offl = 0, cis = 0, byp = 0, pbad = 0;
  logic        sync = 0, trp = 0, p7 = 0, tg = 0, dso = 0;
  logic [9:0]  ev = 10'h0;
  logic [2:0]  phase, rph = 3'h0;
  logic [1:0]  rts = 2'h0, fn;
  logic        ts1, ts2;
  logic [7:0]  idx = 8'h00, bo = 8'h00, usb;
  logic [15:0] bac;
  logic [31:0] q[$];
  int          error_cnt = 0, num_checks = 0, cyc_cnt = 0;
  always #2 clock = ~clock;
  card_seq_model card_seq_model_i (.clock(clock), .arst_n(arst_n), .run(run),
    .req_phase(rph), .req_ts(rts), .phase(phase), .time_state_one(ts1), .time_state_two(ts2));
  card_regs card_regs_i (.clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .device_reset(ev[8]), .bus_init(ev[9]), .phase(phase),
    .time_state_one(ts1), .time_state_two(ts2), .sync_flag(sync),
    .transfer_request_pending(trp), .transfer_granted(tg), .bypass_flag(byp),
    .parity_bad(pbad), .host_bus_timeout(ev[0]), .reset_system(ev[1]),
    .reset_selective(ev[2]), .reset_disconnect(ev[3]), .reject_set(ev[4]),
    .reject_clock(ev[5]), .phase7_clear_signal(p7), .maint_clock_mode(maint),
    .offline(offl), .channel_initiated_sequence(cis), .data_step_in(ev[7]),
    .data_step_out(dso), .unit_address_byte(rnd[7:0]), .bus_out(bo),
    .transfer_data_register(rnd[23:8]), .table_entry_index(idx), .unit_busy_set(ev[6]),
    .bus_address_counter(bac), .unit_status_byte(usb), .io_done_signal(io_done),
    .status_nonzero(snz), .function_bits(fn), .go_bit(go_bit));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d,
                    input logic [3:0] s);
    @(posedge clock);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {a, 2'b00}; sel <= s; dat <= {16'h0, d};
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    wb(1'b1, a, d, 4'h3);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    q.push_back({16'h0, e});
    wb(1'b0, a, 16'h0, 4'h3);
  endtask
  task automatic pulse(input logic [9:0] m);
    @(posedge clock) ev <= m;
    @(posedge clock) ev <= 10'h0;
    @(negedge clock);
  endtask
  task automatic ph(input logic [2:0] p, input logic [1:0] t);
    @(posedge clock) begin run <= 1'b1; rph <= p; rts <= t; end
    @(posedge clock) run <= 1'b0;
    @(posedge clock);
    @(negedge clock);
  endtask
  always @(posedge clock) begin
    if (wb_ack_o === 1'b1 && cyc === 1'b1 && we === 1'b0) begin
      if (q.size() == 0) chk("read queue", 32'h1, 32'h0);
      else chk("read data", wb_dat_o, q.pop_front());
    end
  end
  always @(posedge clock) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[3:0], 16'h0000);
    wr(4'h1, 16'h0016);
    rd(4'h1, 16'h0016);
    chk("function", {30'h0, fn}, 32'h3);
    maint <= 1'b1;
    wr(4'h1, 16'h0001);
    maint <= 1'b0;
    rd(4'h1, 16'h0011);
    pulse(10'h040);
    rd(4'h1, 16'h0019);
    wr(4'h1, 16'h000e);
    pulse(10'h100);
    chk("function kept", {30'h0, fn}, 32'h3);
    rd(4'h1, 16'h000e);
    p7 <= 1'b1;
    @(posedge clock) begin run <= 1'b1; rph <= 3'h7; rts <= 2'h1; end
    pulse(10'h100);
    run <= 1'b0;
    p7 <= 1'b0;
    chk("function clear", {30'h0, fn}, 32'h0);
    wr(4'h2, 16'h1235);
    chk("addr load", {16'h0, bac}, 32'h1235);
    sync <= 1'b1;
    ph(3'h5, 2'h1);
    chk("addr step", {16'h0, bac}, 32'h1237);
    trp <= 1'b1;
    ph(3'h5, 2'h1);
    chk("addr hold", {16'h0, bac}, 32'h1237);
    trp <= 1'b0; sync <= 1'b0; rnd = xs(rnd); idx <= rnd[7:0];
    ph(3'h4, 2'h1);
    chk("addr index", {16'h0, bac}, {15'h0, rnd[7:0], 1'b0} + 32'h1);
    wr(4'h1, 16'h8000);
    wr(4'h2, 16'h4444);
    wr(4'h1, 16'h0000);
    rd(4'h1, 16'h8000);
    chk("addr locked", {16'h0, bac}, {15'h0, rnd[7:0], 1'b0} + 32'h1);
    pulse(10'h200);
    rd(4'h1, 16'h0000);
    wr(4'h1, 16'h0010);
    wr(4'h3, 16'hfffe);
    pulse(10'h080);
    chk("done early", {31'h0, io_done}, 32'h0);
    rd(4'h3, 16'hffff);
    pulse(10'h080);
    chk("done", {31'h0, io_done}, 32'h1);
    rd(4'h3, 16'h0000);
    rd(4'h1, 16'h0000);
    pulse(10'h01f);
    rd(4'h0, 16'h7888);
    pulse(10'h100);
    rd(4'h0, 16'h3808);
    pulse(10'h020);
    rd(4'h0, 16'h3800);
    byp <= 1'b1; pbad <= 1'b1;
    ph(3'h3, 2'h1);
    rd(4'h0, 16'h3800);
    byp <= 1'b0;
    ph(3'h3, 2'h1);
    rd(4'h0, 16'h3820);
    rnd = xs(rnd);
    wb(1'b1, 4'h4, {8'h0, rnd[7:0] | 8'h01}, 4'h1);
    chk("unit status", {24'h0, usb}, {24'h0, rnd[7:0] | 8'h01});
    cis <= 1'b1;
    @(negedge clock) chk("nonzero", {31'h0, snz}, 32'h1);
    cis <= 1'b0;
    @(negedge clock) chk("nonzero idle", {31'h0, snz}, 32'h0);
    bo <= rnd[15:8];
    ph(3'h5, 2'h2);
    chk("bus out byte", {24'h0, usb}, {24'h0, rnd[15:8]});
    wr(4'h5, 16'hffff);
    rd(4'h5, 16'h0000);
    offl <= 1'b1;
    wr(4'h5, 16'hffff);
    rd(4'h5, 16'hfcff);
    @(negedge clock) rnd = xs(rnd);
    ph(3'h1, 2'h1);
    chk("addr unit", {16'h0, bac}, {16'h0, ({7'h0, rnd[7:0], 1'b0} | 16'hfcff) + 16'h1});
    tg <= 1'b1;
    ph(3'h1, 2'h2);
    tg <= 1'b0;
    chk("status low", {24'h0, usb}, {24'h0, rnd[15:8]});
    bo <= rnd[31:24] | 8'h01;
    ph(3'h2, 2'h1);
    chk("addr pointer", {16'h0, bac}, {16'h0, {rnd[23:16], rnd[31:24] | 8'h01} + 16'h1});
    ph(3'h2, 2'h2);
    chk("status cmd odd", {24'h0, usb}, {24'h0, rnd[23:16]});
    dso <= 1'b1;
    ph(3'h6, 2'h2);
    dso <= 1'b0;
    chk("status out", {24'h0, usb}, {24'h0, rnd[15:8]});
    rd(4'h3, 16'h0003);
    @(posedge clock);
    close_out();
  end
endmodule // card_regs_tb
